// file: dv/ars_host.sv
`timescale 1ns/1ps
// host controller model: drives reset pin, conversion trigger and straps
module ars_host (
  input wire logic aclk,
  output logic device_reset_n,
  output logic conversion_trigger,
  output ars_pkg::ars_strap_t straps,
  output logic [2:0] os_code
);
  import ars_pkg::*;
  // gap from reset rise to the next trigger, so no result is corrupted
  localparam int SETTLE_CYC = 8;
  initial begin
    device_reset_n = 1'b1;
    conversion_trigger = 1'b0;
    straps = STRAP_RESET;
    os_code = 3'h0;
  end
  // reset pulse of n cycles, then wait before any trigger
  task automatic pulse_reset(input int n);
    @(posedge aclk);
    device_reset_n <= 1'b0;
    repeat (n) @(posedge aclk);
    device_reset_n <= 1'b1;
    repeat (SETTLE_CYC) @(posedge aclk);
  endtask : pulse_reset
  // pulse held long enough for the two-flop synchroniser
  task automatic trigger();
    @(posedge aclk);
    conversion_trigger <= 1'b1;
    repeat (4) @(posedge aclk);
    conversion_trigger <= 1'b0;
  endtask : trigger
  task automatic set_pins(input ars_strap_t s, input logic [2:0] os);
    @(posedge aclk);
    straps <= s;
    os_code <= os;
  endtask : set_pins
endmodule : ars_host

// file: dv/ars_top_chk.sv
`timescale 1ns/1ps
module ars_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] oversampling_ratio_code,
  input ars_pkg::ars_strap_t strap_snapshot,
  input ars_pkg::ars_cfg_t device_cfg,
  input ars_pkg::ars_rkind_t last_reset_kind,
  input wire logic in_reset,
  input wire logic conv_busy,
  input wire logic [15:0] result_a,
  input wire logic [15:0] result_b,
  input wire logic result_valid
);
  import ars_pkg::*;
  int low_cnt;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // length of the current reset low time, held after release for the kind check
  always_ff @(posedge aclk) begin
    if (!aresetn) low_cnt <= 0;
    else if (in_reset) low_cnt <= $past(in_reset) ? low_cnt + 1 : 1;
  end
  function automatic ars_pin_t pin_of(ars_strap_t s);
    logic sw;
    sw = (s.hw_range == RANGE_SW);
    if (s.if_sel && !s.byte_ser) return ARS_PIN_SERIAL;
    if (s.if_sel) return sw ? ARS_PIN_SW_BYTE : ARS_PIN_HW_BYTE;
    return sw ? ARS_PIN_SW_PAR : ARS_PIN_HW_PAR;
  endfunction : pin_of
  // cfg is one cycle behind the snapshot, so only judge it once settled
  sequence snap_steady;
    $past(aresetn) && $stable(strap_snapshot);
  endsequence
  sequence os_steady;
    ($stable(oversampling_ratio_code) && $stable(strap_snapshot) && !in_reset)[*5];
  endsequence
  a_ref_cfg: assert property (snap_steady |->
    device_cfg.bandgap_en == strap_snapshot.ref_sel && device_cfg.ref_buf_en)
    else $error("reference config wrong");
  a_snap_only_full: assert property (!$stable(strap_snapshot) |->
    last_reset_kind == ARS_RK_FULL) else $error("snapshot moved outside full reset");
  a_abort_clears: assert property (in_reset ##1 in_reset |->
    !conv_busy && !result_valid && result_a == '0 && result_b == '0)
    else $error("results not cleared by reset");
  a_iface_map: assert property (snap_steady |-> device_cfg.iface ==
    (!strap_snapshot.if_sel ? ARS_IF_PARALLEL :
    (strap_snapshot.byte_ser ? ARS_IF_BYTE : ARS_IF_SERIAL))) else $error("iface wrong");
  a_mode_range: assert property (snap_steady |->
    device_cfg.sw_mode == (strap_snapshot.hw_range == RANGE_SW) &&
    device_cfg.seq_active == (strap_snapshot.seq_en && strap_snapshot.hw_range != RANGE_SW))
    else $error("mode decode wrong");
  a_lsb_step: assert property (snap_steady and (strap_snapshot.hw_range != RANGE_SW) |->
    device_cfg.lsb_uv == (strap_snapshot.hw_range == RANGE_2V5 ? LSB_2V5_UV :
    (strap_snapshot.hw_range == RANGE_5V ? LSB_5V_UV : LSB_10V_UV)))
    else $error("code step wrong");
  a_pin_func: assert property (snap_steady |-> device_cfg.pin_func == pin_of(strap_snapshot))
    else $error("pin function wrong");
  a_os_decode: assert property (os_steady |-> device_cfg.sw_mode ||
    device_cfg.os_ratio == 8'(1 << oversampling_ratio_code)) else $error("os ratio wrong");
  a_full_kind: assert property ($fell(in_reset) && low_cnt >= FULL_MIN_CYC + 2 |->
    ##[1:2] last_reset_kind == ARS_RK_FULL) else $error("long reset not full");
  a_partial_kind: assert property ($fell(in_reset) && low_cnt >= PARTIAL_MIN_CYC + 2 &&
    low_cnt <= FULL_MIN_CYC - 2 |-> ##[1:2] last_reset_kind == ARS_RK_PARTIAL)
    else $error("mid reset not partial");
endmodule : ars_chk

bind ars_top ars_chk u_ars_chk (.aclk(aclk), .aresetn(aresetn),
  .oversampling_ratio_code(oversampling_ratio_code), .strap_snapshot(strap_snapshot),
  .device_cfg(device_cfg), .last_reset_kind(last_reset_kind), .in_reset(in_reset),
  .conv_busy(conv_busy), .result_a(result_a), .result_b(result_b),
  .result_valid(result_valid));

// file: dv/tb_adc_reset_strap_config.sv
`timescale 1ns/1ps
module tb_adc_reset_strap_config;
  import ars_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, dev_rst_n, trig, in_reset, busy, valid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] os_code, pair;
  logic [15:0] core_a = 16'h0, core_b = 16'h0, res_a, res_b;
  ars_strap_t pins, snap;
  ars_cfg_t cfg;
  ars_rkind_t kind;
  int failures = 0;
  int comparisons = 0;
  int exp_q[$];
  always #5 aclk = ~aclk;
  ars_host u_ars_host (.aclk(aclk), .device_reset_n(dev_rst_n), .conversion_trigger(trig),
    .straps(pins), .os_code(os_code));
  ars_top u_ars_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .device_reset_n(dev_rst_n), .conversion_trigger(trig),
    .reference_select_strap(pins.ref_sel), .sequencer_enable_strap(pins.seq_en),
    .hardware_range_strap(pins.hw_range), .interface_select_strap(pins.if_sel),
    .byte_or_serial_strap(pins.byte_ser), .oversampling_ratio_code(os_code),
    .core_sample_a(core_a), .core_sample_b(core_b), .strap_snapshot(snap), .device_cfg(cfg),
    .last_reset_kind(kind), .in_reset(in_reset), .conv_busy(busy), .channel_pair(pair),
    .result_a(res_a), .result_b(res_b), .result_valid(valid));
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // a used-up wait is a mismatch and ends the run
  task automatic guard(input int n, input int lim);
    if (n >= lim) begin
      $display("Error wait expected %0d seen %0d", lim, n);
      failures++;
      tally_and_finish();
    end
  endtask : guard
  // write: address and data offered together, each dropped at its own ready
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    guard(n, 50);
    chk("bresp", RESP_OKAY, bresp);
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    guard(n, 50);
    chk("rresp", r, rresp);
    chk("rdata", d, rdata);
  endtask : axi_rd
  initial begin
    ars_strap_t s;
    logic [15:0] a, b;
    int n, k, e;
    void'($urandom(32'hE109));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    // straps latched at full release, one pass per range code
    for (int i = 0; i < 4; i++) begin
      s = ars_strap_t'($urandom);
      s.hw_range = i[1:0];
      u_ars_host.set_pins(s, 3'h0);
      u_ars_host.pulse_reset(200);
      @(negedge aclk);
      chk("snapshot", 32'(s), 32'(snap));
      chk("kind", 32'(ARS_RK_FULL), 32'(kind));
      chk("bandgap", 32'(s.ref_sel), 32'(cfg.bandgap_en));
    end
    $display("test strap capture done");
    // partial reset keeps strap snapshot and programmed control
    axi_wr(CTRL_OFS, 32'h0000_0035);
    u_ars_host.set_pins(~s, 3'h0);
    u_ars_host.pulse_reset(30);
    @(negedge aclk);
    chk("snapshot", 32'(s), 32'(snap));
    chk("kind", 32'(ARS_RK_PARTIAL), 32'(kind));
    axi_rd(CTRL_OFS, 32'h0000_0035, RESP_OKAY);
    u_ars_host.pulse_reset(2);
    chk("kind", 32'(ARS_RK_PARTIAL), 32'(kind));
    s = ars_strap_t'($urandom);
    s.hw_range = RANGE_5V;
    u_ars_host.set_pins(s, 3'h0);
    u_ars_host.pulse_reset(200);
    axi_rd(CTRL_OFS, CTRL_RESET, RESP_OKAY);
    axi_rd(4'h2, 32'h0, RESP_SLVERR);
    $display("test partial and full done");
    // every oversampling code, results compared with the queue model
    for (int c = 0; c < 8; c++) begin
      a = 16'($urandom);
      b = 16'($urandom);
      @(posedge aclk);
      core_a <= a;
      core_b <= b;
      u_ars_host.set_pins(s, c[2:0]);
      repeat (6) @(posedge aclk);
      chk("os_ratio", 32'(1 << c), 32'(cfg.os_ratio));
      exp_q.push_back({b ^ SIGN_FLIP, a ^ SIGN_FLIP});
      n = 0;
      k = 0;
      fork
        u_ars_host.trigger();
      join_none
      while (k < 20000 && !(n > 0 && !busy)) begin
        @(posedge aclk);
        k++;
        if (busy) n++;
      end
      guard(k, 20000);
      e = exp_q.pop_front();
      @(negedge aclk);
      chk("busy_len", 1, 32'(n > (CONV_CYC << c) + 1 ? 0 : n >= (CONV_CYC << c)));
      chk("pair", s.seq_en ? 32'((c + 1) % 8) : 0, 32'(pair));
      chk("valid", 1, 32'(valid));
      chk("result", e, {res_b, res_a});
      axi_rd(RESULT_OFS, e, RESP_OKAY);
    end
    $display("test conversions done");
    // reset in mid-conversion aborts and zeroes the result registers
    fork
      u_ars_host.trigger();
    join_none
    repeat (50) @(posedge aclk);
    u_ars_host.pulse_reset(10);
    @(negedge aclk);
    chk("valid", 0, 32'(valid));
    chk("busy", 0, 32'(busy));
    chk("result", 0, {res_b, res_a});
    axi_rd(RESULT_OFS, 32'h0, RESP_OKAY);
    $display("test abort done");
    tally_and_finish();
  end
endmodule : tb_adc_reset_strap_config

// file: logic/ars_pkg.sv
// How it works
// - oversampling code 000 means none, 001..111 give ratios 2 through 128
// - every result leaves as a 16-bit twos-complement word in all ranges
// - one code step is the full-scale span over 65,536, e.g. 305 uV
// - reference strap high powers the band-gap, low powers it down; buffer always on
// - reference strap is taken at full reset release, later changes ignored
// - reset pin is accepted at any moment, independent of conversion activity
// - length of the reset low time picks partial or full reset
// - partial reset reinitialises internals, keeps software settings and strap snapshots
// - full reset returns every setting to its default
// - reset during a conversion aborts it and marks the data invalid
// - reset during a data read clears all output data registers to zero
// - hardware mode with sequencer strap high at full reset enables the sequencer
// - range straps taken at full reset pick software or hardware mode and range
// - range code 00 software, 01 2.5 V, 10 5 V, 11 10 V bipolar
// - interface strap low gives parallel, high gives serial or byte
// - byte-or-serial strap taken at full reset: high byte, low serial
// - dual-function data pins are assigned from the captured range straps
package ars_pkg;

  localparam int CLK_MHZ = 100;
  // reset length thresholds, in ns
  localparam int PARTIAL_MIN_NS = 50;
  localparam int FULL_MIN_NS = 1200;
  localparam int PARTIAL_MIN_CYC = (PARTIAL_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int FULL_MIN_CYC = (FULL_MIN_NS * CLK_MHZ + 999) / 1000;
  // one conversion of the core, in ns
  localparam int CONV_NS = 1000;
  localparam int CONV_CYC = (CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int RST_CNT_W = 12;
  localparam int BUSY_CNT_W = 16;

  // register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] RANGE_OFS = 4'h4;
  localparam logic [3:0] STATUS_OFS = 4'h8;
  localparam logic [3:0] RESULT_OFS = 4'hC;

  // control fields and default
  localparam int CTRL_OS_LSB = 0;
  localparam int CTRL_BURST_BIT = 3;
  localparam int CTRL_SEQ_LSB = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0070;
  // per-channel range, two bits per channel, default 10 V everywhere
  localparam logic [31:0] RANGE_RESET = 32'hFFFF_FFFF;

  // range codes and code step in microvolts
  localparam logic [1:0] RANGE_SW = 2'h0;
  localparam logic [1:0] RANGE_2V5 = 2'h1;
  localparam logic [1:0] RANGE_5V = 2'h2;
  localparam logic [1:0] RANGE_10V = 2'h3;
  localparam logic [9:0] LSB_2V5_UV = 10'd76;
  localparam logic [9:0] LSB_5V_UV = 10'd152;
  localparam logic [9:0] LSB_10V_UV = 10'd305;
  localparam logic [15:0] SIGN_FLIP = 16'h8000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ARS_IF_PARALLEL, ARS_IF_SERIAL, ARS_IF_BYTE} ars_if_t;
  typedef enum logic [2:0] {
    ARS_PIN_SW_PAR, ARS_PIN_HW_PAR, ARS_PIN_SW_BYTE, ARS_PIN_HW_BYTE, ARS_PIN_SERIAL
  } ars_pin_t;
  typedef enum logic [1:0] {ARS_RK_NONE, ARS_RK_PARTIAL, ARS_RK_FULL} ars_rkind_t;

  // strap snapshot taken at full reset release
  typedef struct packed {
    logic ref_sel;
    logic seq_en;
    logic [1:0] hw_range;
    logic if_sel;
    logic byte_ser;
  } ars_strap_t;
  localparam ars_strap_t STRAP_RESET = '0;

  // derived device configuration
  typedef struct packed {
    logic bandgap_en;
    logic ref_buf_en;
    logic sw_mode;
    logic seq_active;
    ars_if_t iface;
    ars_pin_t pin_func;
    logic [7:0] os_ratio;
    logic [9:0] lsb_uv;
  } ars_cfg_t;

endpackage : ars_pkg

// file: logic/ars_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for pins from outside the clock domain
module ars_sync #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : ars_sync

// file: logic/ars_top.sv
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module ars_top (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // device pins
  input wire logic device_reset_n,
  input wire logic conversion_trigger,
  input wire logic reference_select_strap,
  input wire logic sequencer_enable_strap,
  input wire logic [1:0] hardware_range_strap,
  input wire logic interface_select_strap,
  input wire logic byte_or_serial_strap,
  input wire logic [2:0] oversampling_ratio_code,
  // converter core samples, offset binary, same clock
  input wire logic [15:0] core_sample_a,
  input wire logic [15:0] core_sample_b,
  // outputs
  output ars_pkg::ars_strap_t strap_snapshot,
  output ars_pkg::ars_cfg_t device_cfg,
  output ars_pkg::ars_rkind_t last_reset_kind,
  output logic in_reset,
  output logic conv_busy,
  output logic [2:0] channel_pair,
  output logic [15:0] result_a,
  output logic [15:0] result_b,
  output logic result_valid
);
  import ars_pkg::*;

  // oversampling decode: 000 off, else 2^code
  function automatic logic [7:0] os_ratio_of(input logic [2:0] code);
    logic [7:0] r;
    r = 8'h01;
    if (code != 3'h0) begin
      r = 8'h01 << code;
    end
    return r;
  endfunction : os_ratio_of

  // code step in uV for a range code, span / 65536
  function automatic logic [9:0] lsb_of(input logic [1:0] rc);
    logic [9:0] v;
    case (rc)
      RANGE_2V5: v = LSB_2V5_UV;
      RANGE_5V: v = LSB_5V_UV;
      default: v = LSB_10V_UV;
    endcase
    return v;
  endfunction : lsb_of

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  localparam logic [RST_CNT_W-1:0] PARTIAL_MIN = RST_CNT_W'(PARTIAL_MIN_CYC);
  localparam logic [RST_CNT_W-1:0] FULL_MIN = RST_CNT_W'(FULL_MIN_CYC);
  localparam logic [RST_CNT_W-1:0] RST_CNT_MAX = '1;
  localparam logic [BUSY_CNT_W-1:0] CONV_LEN = BUSY_CNT_W'(CONV_CYC);

  // ---------------- pin synchronisers ----------------
  logic rst_req_s, trig_s;
  logic [5:0] strap_s;
  logic [2:0] os_pin_s;

  // reset pin enters inverted, so the cleared synchroniser reads as released
  ars_sync #(.W(11)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({~device_reset_n, conversion_trigger, reference_select_strap,
        sequencer_enable_strap, hardware_range_strap, interface_select_strap,
        byte_or_serial_strap, oversampling_ratio_code}),
    .q({rst_req_s, trig_s, strap_s, os_pin_s})
  );

  // ---------------- reset length measurement ----------------
  logic rst_prev_reg;
  logic [RST_CNT_W-1:0] low_cnt_reg, low_cnt_next;
  ars_rkind_t rkind_reg;

  // pin is synchronised, so a pulse at any time is seen regardless of activity
  wire rst_low = rst_req_s;
  wire rst_rise = !rst_req_s && rst_prev_reg;
  // saturate so a very long hold still reads as full
  assign low_cnt_next = (low_cnt_reg == RST_CNT_MAX) ? low_cnt_reg : low_cnt_reg + 1'b1;
  // glitches below the partial threshold leave the reset kind unchanged
  wire full_release = rst_rise && (low_cnt_reg >= FULL_MIN);
  wire partial_release = rst_rise && (low_cnt_reg >= PARTIAL_MIN) && !full_release;

  // bus reset acts as power-up; prev starts released so no false rise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_prev_reg <= 1'b0;
      low_cnt_reg <= '0;
      rkind_reg <= ARS_RK_NONE;
    end else begin
      rst_prev_reg <= rst_req_s;
      low_cnt_reg <= rst_low ? low_cnt_next : '0;
      if (full_release) begin
        rkind_reg <= ARS_RK_FULL;
      end else if (partial_release) begin
        rkind_reg <= ARS_RK_PARTIAL;
      end
    end
  end

  // ---------------- strap snapshot ----------------
  ars_strap_t strap_reg;
  ars_strap_t strap_live;
  assign strap_live = strap_s;

  // only a full release recaptures; a partial one keeps the old values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_reg <= STRAP_RESET;
    end else if (full_release) begin
      strap_reg <= strap_live;
    end
  end

  // ---------------- software registers ----------------
  logic [31:0] ctrl_reg, range_reg;
  logic aw_hold_reg, w_hold_reg;
  logic [3:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire wr_go = aw_hold_reg && w_hold_reg && !bvalid_reg;
  wire wr_ctrl = wr_go && (awaddr_reg == CTRL_OFS);
  wire wr_range = wr_go && (awaddr_reg == RANGE_OFS);
  wire wr_known = wr_ctrl || wr_range || (awaddr_reg == STATUS_OFS)
                  || (awaddr_reg == RESULT_OFS);

  // address and data are taken independently, one write at a time
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready = !w_hold_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  // write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // settings survive a partial reset, full release restores defaults
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RESET;
      range_reg <= RANGE_RESET;
    end else if (full_release) begin
      ctrl_reg <= CTRL_RESET;
      range_reg <= RANGE_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg);
      end
      if (wr_range) begin
        range_reg <= merge(range_reg, wdata_reg, wstrb_reg);
      end
    end
  end

  // ---------------- derived configuration ----------------
  wire sw_mode = (strap_reg.hw_range == RANGE_SW);
  wire [2:0] os_code = sw_mode ? ctrl_reg[CTRL_OS_LSB +: 3] : os_pin_s;
  wire burst_en = ctrl_reg[CTRL_BURST_BIT];
  wire [2:0] seq_last = ctrl_reg[CTRL_SEQ_LSB +: 3];
  wire seq_active = !sw_mode && strap_reg.seq_en;
  ars_if_t iface;
  ars_pin_t pin_func;
  logic [1:0] chan_range;

  // interface chosen from the interface and byte-or-serial snapshots
  assign iface = !strap_reg.if_sel ? ARS_IF_PARALLEL :
                 (strap_reg.byte_ser ? ARS_IF_BYTE : ARS_IF_SERIAL);
  // data pin roles follow the range snapshot and the interface
  assign pin_func = (iface == ARS_IF_SERIAL) ? ARS_PIN_SERIAL :
                    (iface == ARS_IF_BYTE) ? (sw_mode ? ARS_PIN_SW_BYTE : ARS_PIN_HW_BYTE) :
                    (sw_mode ? ARS_PIN_SW_PAR : ARS_PIN_HW_PAR);
  // software mode reads the per-channel field, 00 there means 10 V
  assign chan_range = sw_mode ? range_reg[{channel_pair, 1'b0} +: 2] : strap_reg.hw_range;

  // config outputs from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      device_cfg <= '0;
    end else begin
      device_cfg.bandgap_en <= strap_reg.ref_sel;
      device_cfg.ref_buf_en <= 1'b1;
      device_cfg.sw_mode <= sw_mode;
      device_cfg.seq_active <= seq_active;
      device_cfg.iface <= iface;
      device_cfg.pin_func <= pin_func;
      device_cfg.os_ratio <= os_ratio_of(os_code);
      device_cfg.lsb_uv <= lsb_of(chan_range);
    end
  end

  // ---------------- conversion engine ----------------
  logic trig_prev_reg;
  logic busy_reg;
  logic [BUSY_CNT_W-1:0] busy_cnt_reg;
  logic [2:0] pair_reg;
  logic valid_reg;
  logic [15:0] res_a_reg, res_b_reg;
  logic [BUSY_CNT_W-1:0] conv_len;

  wire trig_rise = trig_s && !trig_prev_reg;
  // oversampling stretches the busy time by the ratio
  assign conv_len = BUSY_CNT_W'(CONV_LEN * os_ratio_of(os_code));
  wire conv_done = busy_reg && (busy_cnt_reg == conv_len - 1'b1);
  wire pair_wrap = (pair_reg == seq_last);
  // burst keeps converting until the sequence wraps
  wire burst_more = seq_active && burst_en && !pair_wrap;
  wire start = trig_rise && !busy_reg;

  // reset low aborts, invalidates and zeroes data; settings are untouched
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_prev_reg <= 1'b0;
      busy_reg <= 1'b0;
      busy_cnt_reg <= '0;
      pair_reg <= '0;
      valid_reg <= 1'b0;
      res_a_reg <= '0;
      res_b_reg <= '0;
    end else if (rst_low) begin
      trig_prev_reg <= trig_s;
      busy_reg <= 1'b0;
      busy_cnt_reg <= '0;
      pair_reg <= '0;
      valid_reg <= 1'b0;
      res_a_reg <= '0;
      res_b_reg <= '0;
    end else begin
      trig_prev_reg <= trig_s;
      if (start) begin
        busy_reg <= 1'b1;
        busy_cnt_reg <= '0;
      end else if (conv_done) begin
        busy_reg <= burst_more;
        busy_cnt_reg <= '0;
        // offset binary to twos complement by flipping the sign bit
        res_a_reg <= core_sample_a ^ SIGN_FLIP;
        res_b_reg <= core_sample_b ^ SIGN_FLIP;
        valid_reg <= 1'b1;
        if (seq_active) begin
          pair_reg <= pair_wrap ? 3'h0 : pair_reg + 3'h1;
        end
      end else if (busy_reg) begin
        busy_cnt_reg <= busy_cnt_reg + 1'b1;
      end
    end
  end

  // ---------------- read channel ----------------
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic rd_known;

  assign status_word = {16'h0000, valid_reg, busy_reg, rst_low, rkind_reg,
                        pair_reg, strap_reg, 2'h0};
  assign rd_known = (s_axi_araddr == CTRL_OFS) || (s_axi_araddr == RANGE_OFS)
                    || (s_axi_araddr == STATUS_OFS) || (s_axi_araddr == RESULT_OFS);
  assign rd_word = (s_axi_araddr == CTRL_OFS) ? ctrl_reg :
                   (s_axi_araddr == RANGE_OFS) ? range_reg :
                   (s_axi_araddr == STATUS_OFS) ? status_word :
                   (s_axi_araddr == RESULT_OFS) ? {res_b_reg, res_a_reg} : 32'h0000_0000;

  // one read at a time, data held until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ---------------- outputs ----------------
  assign strap_snapshot = strap_reg;
  assign last_reset_kind = rkind_reg;
  assign in_reset = rst_low;
  assign conv_busy = busy_reg;
  assign channel_pair = pair_reg;
  assign result_a = res_a_reg;
  assign result_b = res_b_reg;
  assign result_valid = valid_reg;

endmodule : ars_top
